// [piso_shifter.sv]
// parallel-in or serial-in, serial-out shift register with true and inverted outputs
`timescale 1ns/100ps

module piso_shifter
	import shifter_pkg::*;
#(
	parameter int STAGES = STAGE_COUNT
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_shift_not_load,
	input wire logic i_shift_clock,
	input wire logic i_clock_inhibit,
	input wire logic i_serial_in,
	input wire logic [STAGES-1:0] i_parallel_in,
	output logic o_serial_out,
	output logic o_serial_out_n
);

	// a chain needs at least a first stage and a separate output stage
	if (STAGES < 2) begin : g_bad_stages
		$error("piso_shifter: STAGES must be at least 2");
	end

	// stage 0 is the first stage, stage STAGES-1 drives the serial output
	logic [STAGES-1:0] stage;
	logic inverted_out;
	logic [STAGES-1:0] next_stage;
	logic next_inverted_out;
	logic [STAGES-1:0] shifted;
	logic shift_step;
	mode_t mode;

	// qualified step on either clock input
	// previous levels reset high, so a level already high at release never shifts
	clock_qualifier u_clock_qualifier (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_shift_clock(i_shift_clock),
		.i_clock_inhibit(i_clock_inhibit),
		.o_shift_step(shift_step)
	);

	// chain moved one place, serial input entering stage 0
	assign shifted[0] = i_serial_in;
	for (genvar g = 1; g < STAGES; g++) begin : g_shift
		assign shifted[g] = stage[g-1];
	end

	// mode decode: load wins over any clock activity
	always_comb begin
		if (!i_shift_not_load) begin
			mode = MODE_LOAD;
		end else if (shift_step) begin
			mode = MODE_SHIFT;
		end else begin
			mode = MODE_HOLD;
		end
	end

	// next stage contents and inverted copy of the output stage
	always_comb begin
		case (mode)
			MODE_LOAD: begin
				next_stage = i_parallel_in;
			end
			MODE_SHIFT: begin
				next_stage = shifted;
			end
			MODE_HOLD: begin
				next_stage = stage;
			end
			default: begin
				next_stage = stage;
			end
		endcase
		next_inverted_out = ~next_stage[STAGES-1];
	end

	// data stages carry no reset, like the volatile latches they model
	// a low control reloads on every edge, a per-cycle stand-in for the asynchronous load
	always_ff @(posedge i_clock) begin
		stage <= next_stage;
		inverted_out <= next_inverted_out;
	end

	// both outputs straight from flip-flops
	assign o_serial_out = stage[STAGES-1];
	assign o_serial_out_n = inverted_out;

	// helper: contents are defined once a load has taken place
	logic loaded;
	logic next_loaded;

	// set by the first load, cleared only by reset
	always_comb begin
		next_loaded = loaded | ~i_shift_not_load;
	end

	// helper flag registered with an asynchronous clear
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			loaded <= 1'b0;
		end else begin
			loaded <= next_loaded;
		end
	end

	// load copies every parallel input into its stage
	a_load_copies_inputs: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!i_shift_not_load |=> stage == $past(i_parallel_in))
		else $error("parallel load did not copy the inputs");

	// last parallel input reaches the serial output one cycle after load
	a_load_drives_output: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!i_shift_not_load |=> o_serial_out == $past(i_parallel_in[STAGES-1]))
		else $error("serial output does not follow the last parallel input");

	// a shift moves the chain toward the output
	a_shift_moves_chain: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && shift_step
		|=> stage[STAGES-1:1] == $past(stage[STAGES-2:0]))
		else $error("shift did not move the stages one place");

	// a shift captures the serial input in the first stage
	a_shift_takes_serial: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_shift_not_load && shift_step |=> stage[0] == $past(i_serial_in))
		else $error("first stage did not take the serial input");

	// no qualified step with control high keeps every stage
	a_hold_keeps_stages: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && !shift_step |=> stage == $past(stage))
		else $error("stages changed without a qualified step");

	// clock rising while inhibit low gives a shift, high clock gives none
	a_clock_rise_shifts: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && !i_clock_inhibit && i_shift_clock
		&& !$past(i_shift_clock) && $past(loaded) |=> stage[0] == $past(i_serial_in)
		&& stage[STAGES-1:1] == $past(stage[STAGES-2:0]))
		else $error("clock rising with inhibit low did not shift");

	// inhibit held high blocks any clock step
	a_inhibit_blocks_clock: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && i_clock_inhibit && $past(i_clock_inhibit)
		##1 loaded && i_shift_not_load && i_clock_inhibit
		|-> stage == $past(stage))
		else $error("stages moved while clock inhibit stayed high");

	// true and inverted outputs always opposite once defined
	a_outputs_opposite: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded |-> o_serial_out_n == ~o_serial_out)
		else $error("inverted output equals the true output");

	// every stage after stage 0 takes its neighbour's old value on a shift
	for (genvar g = 1; g < STAGES; g++) begin : g_stage_check
		a_stage_takes_neighbour: assert property (@(posedge i_clock) disable iff (i_sys_rst)
			loaded && i_shift_not_load && shift_step |=> stage[g] == $past(stage[g-1]))
			else $error("a stage did not take its neighbour on a shift");
	end

	// inhibit rising while the clock is low acts as the clock
	a_inhibit_rise_shifts: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && !i_shift_clock && i_clock_inhibit
		&& !$past(i_clock_inhibit) && $past(loaded) |=> stage[0] == $past(i_serial_in)
		&& stage[STAGES-1:1] == $past(stage[STAGES-2:0]))
		else $error("inhibit rising with clock low did not shift");

	// a clock input already high gives no step, whatever the inhibit does
	a_clock_high_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && i_shift_clock && $past(i_shift_clock)
		|=> stage == $past(stage))
		else $error("stages moved while the clock stayed high");

	// inverted output shows the opposite of the loaded last input
	a_inverted_follows_load: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!i_shift_not_load |=> o_serial_out_n == ~$past(i_parallel_in[STAGES-1]))
		else $error("inverted output does not oppose the last parallel input");

	// both clock inputs high never count as a step
	a_both_high_no_step: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_shift_clock && i_clock_inhibit |-> !shift_step)
		else $error("a step was taken with both clock inputs high");

	// both clock inputs low can never shift
	a_both_low_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && !i_shift_clock && !i_clock_inhibit
		|=> stage == $past(stage))
		else $error("stages moved with both clock inputs low");

	// load wins even when a clock step arrives in the same cycle
	a_load_beats_step: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!i_shift_not_load && shift_step |=> stage == $past(i_parallel_in))
		else $error("a clock step overrode the parallel load");

	// every step comes from one input rising while the other is low
	a_step_needs_rise: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		shift_step |-> (i_shift_clock && !$past(i_shift_clock) && !i_clock_inhibit)
		|| (i_clock_inhibit && !$past(i_clock_inhibit) && !i_shift_clock))
		else $error("a step was taken without a qualified rising input");

	// inhibit high for two samples never lets the stages move
	a_inhibit_high_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && i_clock_inhibit && $past(i_clock_inhibit)
		|=> stage == $past(stage))
		else $error("stages moved while clock inhibit was high");

	// a shift puts the old next-to-last stage on both outputs
	a_shift_feeds_output: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		loaded && i_shift_not_load && shift_step |=> o_serial_out == $past(stage[STAGES-2])
		&& o_serial_out_n == ~$past(stage[STAGES-2]))
		else $error("outputs did not show the shifted stage");

endmodule : piso_shifter

// [shifter_pkg.sv]
// shared constants, modes and decode helpers for the parallel-in serial-out shifter
package shifter_pkg;

	// number of storage stages in the chain
	localparam int STAGE_COUNT = 8;

	// level assumed for both clock inputs before the first sample after reset
	localparam logic PREV_LEVEL_RESET = 1'b1;

	// one-hot operating modes of the stage chain
	typedef enum logic [2:0] {
		MODE_HOLD = 3'h1,
		MODE_LOAD = 3'h2,
		MODE_SHIFT = 3'h4
	} mode_t;

	// low-to-high step on one clock input while the other one is low
	function automatic logic qualified_rise(input logic now_level, input logic prev_level,
		input logic other_level);
		qualified_rise = now_level & ~prev_level & ~other_level;
	endfunction : qualified_rise

endpackage : shifter_pkg

// [clock_qualifier.sv]
// detects a qualified shift step on either of the two interchangeable clock inputs
`timescale 1ns/100ps

module clock_qualifier
	import shifter_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_shift_clock,
	input wire logic i_clock_inhibit,
	output logic o_shift_step
);

	logic prev_clock;
	logic prev_inhibit;
	logic next_prev_clock;
	logic next_prev_inhibit;

	// either input may act as the clock while the other one blocks it
	always_comb begin
		next_prev_clock = i_shift_clock;
		next_prev_inhibit = i_clock_inhibit;
		o_shift_step = qualified_rise(i_shift_clock, prev_clock, i_clock_inhibit) |
			qualified_rise(i_clock_inhibit, prev_inhibit, i_shift_clock);
	end

	// previous levels start high so no false step follows reset
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prev_clock <= PREV_LEVEL_RESET;
			prev_inhibit <= PREV_LEVEL_RESET;
		end else begin
			prev_clock <= next_prev_clock;
			prev_inhibit <= next_prev_inhibit;
		end
	end

endmodule : clock_qualifier

// [upstream_register.sv]
// chained upstream register model feeding the shifter serial input
`timescale 1ns/100ps

module upstream_register (
	input wire logic i_clock,
	input wire logic i_load,
	input wire logic i_step,
	input wire logic [7:0] i_data,
	output logic o_serial_out
);
	logic [7:0] chain;
	// loads a word, then hands its msb on at each shared step
	always_ff @(posedge i_clock) begin
		if (i_load) begin
			chain <= i_data;
		end else if (i_step) begin
			chain <= {chain[6:0], ~chain[0]};
		end
	end
	// last stage drives the next device in the chain
	assign o_serial_out = chain[7];
endmodule : upstream_register

// [tb_top.sv]
// self-checking bench for the shifter with a chained upstream register
`timescale 1ns/100ps

module tb_top;
	import shifter_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic snl = 1'b1, sclk = 1'b0, inh = 1'b0, step = 1'b0, up_load = 1'b0;
	logic [7:0] par = 8'h00, up_data = 8'h00;
	logic [15:0] m;
	logic serial_in, q, qn, u;
	logic q_exp[$];
	int bad_count = 0, n_checks = 0, r, k;
	integer seed = 32'hb11c9a9a;

	piso_shifter #(.STAGES(8)) piso_shifter_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_shift_not_load(snl), .i_shift_clock(sclk), .i_clock_inhibit(inh),
		.i_serial_in(serial_in), .i_parallel_in(par), .o_serial_out(q), .o_serial_out_n(qn));
	upstream_register upstream_register_inst (.i_clock(i_clock), .i_load(up_load),
		.i_step(step), .i_data(up_data), .o_serial_out(serial_in));

	// free-running clock
	always #4 i_clock = ~i_clock;

	task check(input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// drives one cycle, notes the expected output after its edge
	task automatic cyc(input logic l, input logic c, input logic h, input logic s,
		input logic e);
		snl = l;
		sclk = c;
		inh = h;
		step = s;
		@(posedge i_clock);
		q_exp.push_back(e);
		#1;
	endtask : cyc

	// compares settled outputs against the oldest note
	always @(posedge i_clock) begin : mon
		logic e;
		#2;
		if (q_exp.size() > 0) begin
			e = q_exp.pop_front();
			check(q, e);
			check(qn, ~e);
		end
	end

	// watchdog
	initial begin
		#20000;
		bad_count++;
		tally_and_finish();
	end

	// load, blocked steps, then fifteen shifts per round on alternating inputs
	initial begin
		repeat (12) @(posedge i_clock);
		#1 i_sys_rst = 1'b0;
		for (r = 0; r < 4; r++) begin
			par = 8'($random(seed));
			up_data = 8'($random(seed));
			m = {par, up_data};
			u = r[0];
			up_load = 1'b1;
			cyc(1'b0, 1'b0, 1'b0, 1'b0, m[15]);
			up_load = 1'b0;
			par = 8'($random(seed));
			m[15:8] = par;
			cyc(1'b0, 1'b1, 1'b0, 1'b0, m[15]);
			for (k = 1; k < 16; k++) begin
				cyc(1'b1, 1'b1, 1'b1, 1'b0, m[16-k]);
				cyc(1'b1, 1'b0, 1'b0, 1'b0, m[16-k]);
				cyc(1'b1, ~u, u, 1'b1, m[15-k]);
			end
			// inhibit held high while the clock toggles
			for (k = 0; k < 5; k++) begin
				cyc(1'b1, ~k[0], 1'b1, 1'b0, m[0]);
			end
		end
		repeat (2) @(posedge i_clock);
		#3;
		tally_and_finish();
	end
endmodule : tb_top
